// ### logic/wdp_top.sv
/*
  Supervisor timer and periodic interrupt timer with register port.
  Assumes a plain register port (read data one cycle after the strobe),
  system reset driving rst_n, power-on reset driving por_n, and an
  interrupt controller that acknowledges the request.
*/
// Added by the designer: strobed register access.
// Operation
// - Key 55h arms; a following AAh while armed clears the counter.
// - Any key value other than 55h or AAh forces a system reset.
// - Repeated 55h keeps arming; AAh when not armed is ignored.
// - A clear disarms; another 55h is needed for the next clear.
// - Overflow or bad key sets the cause flag; flag survives reset.
// - A set cause flag never blocks later resets; software clears it.
// - Overflow resets the system one counting period later.
// - Software alone cannot turn off overflow reset; the defeat bit also needs programming voltage at reset.
// - Disabled only with programming voltage at reset plus defeat bit.
// - Check bits are compared with 101 always; mismatch resets.
// - After reset the tap select gives the fastest overflow rate.
// - Counter runs from reset release without any software setup.
// - Periodic source is one of eight taps under select bits 2-0.
// - Periodic counter advances on the divide-by-128 prescale event.
// - Periodic counter is readable and clearable any time.
// - Free-running counter is cleared only by system reset.
// - Periodic timer runs in every mode except halt.
// - With enable set, one request per transition of the tap.
// - Bit 7 sets on each overflow; clearable; software set no irq.
// - Supervisor counter taps timebase directly or six prescale taps.
// - Any write to the periodic counter clears it to zero.
`timescale 1ns/100ps
`include "wdp_defs.svh"

module wdp_top
  import wdp_pkg::*;
#(
  parameter int CNT_W = 8,
  parameter int FR_W = 7
) (
  // Clock and resets
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic por_n,
  // Timebase and mode pins
  input wire logic slow_timebase_clock,
  input wire logic halt_mode,
  input wire logic programming_voltage_pin,
  // Register port
  input wire wdp_bus_req_t bus_req,
  output logic [7:0] rd_data,
  // System reset request
  output logic sys_reset_req,
  // Periodic interrupt
  output logic periodic_irq,
  input wire logic periodic_irq_ack
);

  // ************************************************************
  // Decode helpers
  // ************************************************************
  function automatic logic reg_hit(input logic [15:0] addr,
                                   input logic [15:0] offset);
    return addr == offset;
  endfunction

  // True when all bits of v below position n are ones
  function automatic logic carry_into(input logic [7:0] v, input int n);
    logic r;
    r = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (i < n) begin
        r = r & v[i];
      end
    end
    return r;
  endfunction

  // ************************************************************
  // Declarations
  // ************************************************************
  logic tb_tick;
  logic [FR_W-1:0] fr_count;
  logic [7:0] fr_evt;
  logic [7:0] pc_evt;
  logic wd_tick;
  logic periodic_evt;
  logic wr_pcount;
  logic wr_key;
  logic wr_pctrl;
  logic wr_sctrl;
  logic key_bad;
  logic key_clear;
  logic check_bad;
  logic wd_disabled;
  logic ovf_fire;
  logic [7:0] pctrl_view;
  logic [7:0] sctrl_view;

  logic [CNT_W-1:0] periodic_count_r;
  logic [CNT_W-1:0] supervisor_count_r;
  wdp_key_state_t key_state_r;
  wdp_wd_state_t wd_state_r;
  logic periodic_overflow_flag_r;
  logic periodic_irq_enable_r;
  logic [2:0] periodic_tap_select_r;
  logic supervisor_cause_flag_r;
  logic supervisor_defeat_bit_r;
  logic [2:0] integrity_check_bits_r;
  logic [2:0] supervisor_tap_select_r;
  logic vpp_caught_r;
  logic strap_done_r;
  logic irq_pend_r;
  logic sys_reset_r;
  logic [7:0] rd_data_r;

  // ************************************************************
  // Prescaler
  // ************************************************************
  wdp_prescaler #(
    .FR_W(FR_W)
  ) u_prescaler (
    .mclk(mclk),
    .rst_n(rst_n),
    .slow_timebase_clock(slow_timebase_clock),
    .tb_tick(tb_tick),
    .fr_count(fr_count)
  );

  // ************************************************************
  // Tap events
  // ************************************************************
  // fr_evt[n]: divide-by-2^n event of the free-running counter
  // pc_evt[n]: divide-by-128*2^n event of the periodic counter
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_taps
      assign fr_evt[gi] = tb_tick & carry_into({1'b0, fr_count}, gi);
      assign pc_evt[gi] = fr_evt[7] & carry_into(periodic_count_r, gi);
    end
  endgenerate

  // Two direct selections, then six prescale taps
  always_comb begin
    if (supervisor_tap_select_r <= `WDP_DIRECT_SEL_MAX) begin
      wd_tick = fr_evt[0];
    end else begin
      wd_tick = fr_evt[supervisor_tap_select_r - 3'h1];
    end
  end

  // One-of-eight periodic source
  always_comb begin
    case (periodic_tap_select_r)
      3'h0: periodic_evt = fr_evt[2];
      3'h1: periodic_evt = fr_evt[4];
      3'h2: periodic_evt = fr_evt[6];
      3'h3: periodic_evt = fr_evt[7];
      3'h4: periodic_evt = pc_evt[1];
      3'h5: periodic_evt = pc_evt[2];
      3'h6: periodic_evt = pc_evt[4];
      3'h7: periodic_evt = pc_evt[7];
      default: periodic_evt = 1'b0;
    endcase
  end

  // ************************************************************
  // Write decode
  // ************************************************************
  assign wr_pcount = bus_req.wr &
                     reg_hit(bus_req.addr, `WDP_ADDR_PERIODIC_COUNT);
  assign wr_key = bus_req.wr & reg_hit(bus_req.addr, `WDP_ADDR_SERVICE_KEY);
  assign wr_pctrl = bus_req.wr &
                    reg_hit(bus_req.addr, `WDP_ADDR_PERIODIC_CONTROL);
  assign wr_sctrl = bus_req.wr &
                    reg_hit(bus_req.addr, `WDP_ADDR_SUPERVISOR_CONTROL);

  // Invalid key value
  assign key_bad = wr_key & (bus_req.wdata != `WDP_KEY_ARM) &
                   (bus_req.wdata != `WDP_KEY_CLEAR);
  // AAh counts only while armed
  assign key_clear = wr_key & (bus_req.wdata == `WDP_KEY_CLEAR) &
                     (key_state_r == KEY_ARMED);

  // Continuous compare of the stored check pattern
  assign check_bad = integrity_check_bits_r != `WDP_CHECK_OK;

  // Both conditions needed to defeat counting
  assign wd_disabled = vpp_caught_r & supervisor_defeat_bit_r;

  // Delayed overflow reset, one counting period later
  assign ovf_fire = (wd_state_r == WD_OVERFLOWED) & wd_tick & ~key_clear;

  // ************************************************************
  // Programming voltage strap
  // ************************************************************
  // Caught on the first edge after reset release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_r <= 1'b0;
      vpp_caught_r <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      vpp_caught_r <= programming_voltage_pin;
    end
  end

  // ************************************************************
  // Key sequence
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      key_state_r <= KEY_IDLE;
    end else if (wr_key) begin
      case (key_state_r)
        KEY_IDLE: begin
          if (bus_req.wdata == `WDP_KEY_ARM) begin
            key_state_r <= KEY_ARMED;
          end
        end
        KEY_ARMED: begin
          if (bus_req.wdata == `WDP_KEY_CLEAR) begin
            key_state_r <= KEY_IDLE;
          end
        end
        default: key_state_r <= KEY_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Supervisor counter
  // ************************************************************
  // Counts from reset release with no setup
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      supervisor_count_r <= `WDP_ZERO8;
      wd_state_r <= WD_RUN;
    end else if (key_clear) begin
      supervisor_count_r <= `WDP_ZERO8;
      wd_state_r <= WD_RUN;
    end else if (wd_disabled) begin
      wd_state_r <= WD_RUN;
    end else if (wd_tick) begin
      supervisor_count_r <= supervisor_count_r + 8'h01;
      case (wd_state_r)
        WD_RUN: begin
          if (supervisor_count_r == `WDP_COUNT_MAX) begin
            wd_state_r <= WD_OVERFLOWED;
          end
        end
        WD_OVERFLOWED: wd_state_r <= WD_RUN;
        default: wd_state_r <= WD_RUN;
      endcase
    end
  end

  // ************************************************************
  // System reset request
  // ************************************************************
  // Flag state plays no part here
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sys_reset_r <= 1'b0;
    end else begin
      sys_reset_r <= key_bad | check_bad | ovf_fire;
    end
  end

  // ************************************************************
  // Cause flag
  // ************************************************************
  // Power-on reset or a write of 1 to bit 7 clears it; system reset keeps it
  always_ff @(posedge mclk or negedge por_n) begin
    if (!por_n) begin
      supervisor_cause_flag_r <= 1'b0;
    end else if (ovf_fire | key_bad) begin
      supervisor_cause_flag_r <= 1'b1;
    end else if (wr_sctrl & bus_req.wdata[`WDP_SC_FLAG_BIT]) begin
      supervisor_cause_flag_r <= 1'b0;
    end
  end

  // ************************************************************
  // Supervisor control
  // ************************************************************
  // Fastest rate after reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      supervisor_defeat_bit_r <= 1'b0;
      integrity_check_bits_r <= `WDP_CHECK_OK;
      supervisor_tap_select_r <= `WDP_SEL_RST;
    end else if (wr_sctrl) begin
      supervisor_defeat_bit_r <= bus_req.wdata[`WDP_SC_DEFEAT_BIT];
      // A bad pattern is stored and then trips the compare
      integrity_check_bits_r <=
        bus_req.wdata[`WDP_SC_CHECK_HI:`WDP_SC_CHECK_LO];
      supervisor_tap_select_r <= bus_req.wdata[`WDP_SC_SEL_HI:`WDP_SC_SEL_LO];
    end
  end

  // ************************************************************
  // Periodic counter
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      periodic_count_r <= `WDP_ZERO8;
    end else if (wr_pcount) begin
      periodic_count_r <= `WDP_ZERO8;
    end else if (fr_evt[7] & ~halt_mode) begin
      periodic_count_r <= periodic_count_r + 8'h01;
    end
  end

  // ************************************************************
  // Periodic control
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      periodic_irq_enable_r <= 1'b0;
      periodic_tap_select_r <= `WDP_SEL_RST;
    end else if (wr_pctrl) begin
      periodic_irq_enable_r <= bus_req.wdata[`WDP_PC_IRQ_EN_BIT];
      periodic_tap_select_r <= bus_req.wdata[`WDP_PC_SEL_HI:`WDP_PC_SEL_LO];
    end
  end

  // Hardware set wins over a software clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      periodic_overflow_flag_r <= 1'b0;
    end else if (periodic_evt & ~halt_mode) begin
      periodic_overflow_flag_r <= 1'b1;
    end else if (wr_pctrl) begin
      periodic_overflow_flag_r <= bus_req.wdata[`WDP_PC_FLAG_BIT];
    end
  end

  // ************************************************************
  // Periodic interrupt request
  // ************************************************************
  // One request per selected tap event, never from the flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_pend_r <= 1'b0;
    end else if (periodic_evt & ~halt_mode & periodic_irq_enable_r) begin
      irq_pend_r <= 1'b1;
    end else if (periodic_irq_ack | ~periodic_irq_enable_r) begin
      irq_pend_r <= 1'b0;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  assign pctrl_view = {periodic_overflow_flag_r, periodic_irq_enable_r,
                       3'h0, periodic_tap_select_r};
  assign sctrl_view = {supervisor_cause_flag_r, supervisor_defeat_bit_r,
                       integrity_check_bits_r, supervisor_tap_select_r};

  // Key address reads back the supervisor control contents
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= `WDP_ZERO8;
    end else if (!bus_req.rd) begin
      rd_data_r <= `WDP_ZERO8;
    end else if (reg_hit(bus_req.addr, `WDP_ADDR_PERIODIC_COUNT)) begin
      rd_data_r <= periodic_count_r;
    end else if (reg_hit(bus_req.addr, `WDP_ADDR_SUPERVISOR_COUNT)) begin
      rd_data_r <= supervisor_count_r;
    end else if (reg_hit(bus_req.addr, `WDP_ADDR_SERVICE_KEY)) begin
      rd_data_r <= sctrl_view;
    end else if (reg_hit(bus_req.addr, `WDP_ADDR_PERIODIC_CONTROL)) begin
      rd_data_r <= pctrl_view;
    end else if (reg_hit(bus_req.addr, `WDP_ADDR_SUPERVISOR_CONTROL)) begin
      rd_data_r <= sctrl_view;
    end else begin
      rd_data_r <= `WDP_ZERO8;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign rd_data = rd_data_r;
  assign sys_reset_req = sys_reset_r;
  assign periodic_irq = irq_pend_r;

endmodule

// ### logic/wdp_defs.svh
/*
  Register offsets, field positions, key values and reset values of the
  supervisor timer and periodic interrupt timer block.
  Assumes it is included by bare name from the top, prescaler and checker modules.
*/
`ifndef WDP_DEFS_SVH
`define WDP_DEFS_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define WDP_ADDR_PERIODIC_COUNT 16'h7021
`define WDP_ADDR_SUPERVISOR_COUNT 16'h7023
`define WDP_ADDR_SERVICE_KEY 16'h7025
`define WDP_ADDR_PERIODIC_CONTROL 16'h7027
`define WDP_ADDR_SUPERVISOR_CONTROL 16'h7029

// ************************************************************
// Field positions
// ************************************************************
`define WDP_PC_FLAG_BIT 7
`define WDP_PC_IRQ_EN_BIT 6
`define WDP_PC_SEL_HI 2
`define WDP_PC_SEL_LO 0
`define WDP_SC_FLAG_BIT 7
`define WDP_SC_DEFEAT_BIT 6
`define WDP_SC_CHECK_HI 5
`define WDP_SC_CHECK_LO 3
`define WDP_SC_SEL_HI 2
`define WDP_SC_SEL_LO 0

// ************************************************************
// Key values, check pattern, reset values
// ************************************************************
`define WDP_KEY_ARM 8'h55
`define WDP_KEY_CLEAR 8'hAA
`define WDP_CHECK_OK 3'h5
`define WDP_SEL_RST 3'h0
`define WDP_ZERO8 8'h00
`define WDP_ZERO7 7'h00
`define WDP_COUNT_MAX 8'hFF
`define WDP_DIRECT_SEL_MAX 3'h1

`endif

// ### logic/wdp_pkg.sv
/*
  Types shared by the supervisor timer block: bus request carrier and
  state enumerations.
  Assumes the defines header sits beside it.
*/
package wdp_pkg;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wdp_bus_req_t;

  typedef enum logic {
    KEY_IDLE,
    KEY_ARMED
  } wdp_key_state_t;

  typedef enum logic {
    WD_RUN,
    WD_OVERFLOWED
  } wdp_wd_state_t;

endpackage

// ### logic/wdp_prescaler.sv
/*
  Timebase edge detector and 7-bit free-running prescale counter.
  Assumes the slow timebase clock is a level synchronous to mclk and
  that it is absent (stands still) in oscillator power-down.
*/
`timescale 1ns/100ps
`include "wdp_defs.svh"

module wdp_prescaler
  import wdp_pkg::*;
#(
  parameter int FR_W = 7
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Timebase
  input wire logic slow_timebase_clock,
  // Prescale outputs
  output logic tb_tick,
  output logic [FR_W-1:0] fr_count
);

  logic tb_prev_r;
  logic [FR_W-1:0] fr_count_r;

  // ************************************************************
  // Timebase rising edge
  // ************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tb_prev_r <= 1'b0;
    end else begin
      tb_prev_r <= slow_timebase_clock;
    end
  end

  assign tb_tick = slow_timebase_clock & ~tb_prev_r;

  // ************************************************************
  // Free-running counter
  // ************************************************************
  // Only reset clears it; no software path reaches it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fr_count_r <= `WDP_ZERO7;
    end else if (tb_tick) begin
      fr_count_r <= fr_count_r + 7'h01;
    end
  end

  assign fr_count = fr_count_r;

endmodule

// ### tb/wdp_checker.sv
/*
  Concurrent checks on the ports of the supervisor and periodic timer top.
  Assumes the bench owns rst_n and holds it high a few cycles after faults.
*/
`timescale 1ns/100ps
`include "wdp_defs.svh"

module wdp_checker
  import wdp_pkg::*;
#(
  parameter int CNT_W = 8,
  parameter int FR_W = 7
) (
  // Clock and resets
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic por_n,
  // Timebase and mode pins
  input wire logic slow_timebase_clock,
  input wire logic halt_mode,
  input wire logic programming_voltage_pin,
  // Register port
  input wire wdp_bus_req_t bus_req,
  input wire logic [7:0] rd_data,
  // Reset request and interrupt
  input wire logic sys_reset_req,
  input wire logic periodic_irq,
  input wire logic periodic_irq_ack
);
  logic key_wr;
  logic ctl_wr;
  logic pc_wr;
  logic cnt_wr;
  logic mapped;

  // ************************************************************
  // Decoded requests
  // ************************************************************
  assign key_wr = bus_req.wr && bus_req.addr == `WDP_ADDR_SERVICE_KEY;
  assign ctl_wr = bus_req.wr && bus_req.addr == `WDP_ADDR_SUPERVISOR_CONTROL;
  assign pc_wr = bus_req.wr && bus_req.addr == `WDP_ADDR_PERIODIC_CONTROL;
  assign cnt_wr = bus_req.wr && bus_req.addr == `WDP_ADDR_PERIODIC_COUNT;
  assign mapped = bus_req.addr inside {`WDP_ADDR_PERIODIC_COUNT,
    `WDP_ADDR_SUPERVISOR_COUNT, `WDP_ADDR_SERVICE_KEY,
    `WDP_ADDR_PERIODIC_CONTROL, `WDP_ADDR_SUPERVISOR_CONTROL};

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // ************************************************************
  // Assertions
  // ************************************************************
  bad_key_a: assert property (key_wr && bus_req.wdata != `WDP_KEY_ARM &&
    bus_req.wdata != `WDP_KEY_CLEAR |=> sys_reset_req)
    else $error("bad key gave no reset request");
  check_bits_a: assert property (ctl_wr &&
    bus_req.wdata[5:3] != `WDP_CHECK_OK |-> ##2 sys_reset_req [*3])
    else $error("bad check bits gave no held reset request");
  rd_idle_a: assert property (!bus_req.rd |=> rd_data == 8'h00)
    else $error("read data not zero outside read slot");
  unmapped_rd_a: assert property (bus_req.rd && !mapped |=>
    rd_data == 8'h00)
    else $error("unmapped read not zero");
  count_clear_a: assert property (cnt_wr ##2 (bus_req.rd &&
    bus_req.addr == `WDP_ADDR_PERIODIC_COUNT) |=> rd_data <= 8'h01)
    else $error("periodic count not cleared by write");
  rsvd_zero_a: assert property (bus_req.rd &&
    bus_req.addr == `WDP_ADDR_PERIODIC_CONTROL |=> rd_data[5:3] == 3'h0)
    else $error("reserved periodic control bits not zero");
  key_view_a: assert property (bus_req.rd && !sys_reset_req &&
    bus_req.addr == `WDP_ADDR_SERVICE_KEY |=> rd_data[5:3] == 3'h5)
    else $error("key address read lacks check pattern");
  irq_off_a: assert property (pc_wr && !bus_req.wdata[6] |->
    ##3 !periodic_irq)
    else $error("request stays with enable cleared");
  halt_quiet_a: assert property ($rose(periodic_irq) |->
    !$past(halt_mode))
    else $error("periodic request raised in halt");

  // ************************************************************
  // Coverage
  // ************************************************************
  clear_key_c: cover property (key_wr && bus_req.wdata == `WDP_KEY_CLEAR);
  reset_req_c: cover property ($rose(sys_reset_req));
  irq_rise_c: cover property ($rose(periodic_irq));
endmodule

bind wdp_top wdp_checker #(.CNT_W(CNT_W), .FR_W(FR_W)) u_wdp_checker (
  .mclk(mclk), .rst_n(rst_n), .por_n(por_n),
  .slow_timebase_clock(slow_timebase_clock), .halt_mode(halt_mode),
  .programming_voltage_pin(programming_voltage_pin), .bus_req(bus_req),
  .rd_data(rd_data), .sys_reset_req(sys_reset_req),
  .periodic_irq(periodic_irq), .periodic_irq_ack(periodic_irq_ack));

// ### tb/wdp_tb.sv
/*
  Self-checking bench for the supervisor and periodic timer top.
  Assumes the bench stands in for system reset, timebase and interrupt ack.
*/
`timescale 1ns/100ps

module tb
  import wdp_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic por_n = 1'b0;
  logic slow_timebase_clock = 1'b0;
  logic halt_mode = 1'b0;
  logic programming_voltage_pin = 1'b0;
  wdp_bus_req_t bus_req = '0;
  logic [7:0] rd_data;
  logic sys_reset_req;
  logic periodic_irq;
  logic periodic_irq_ack = 1'b0;
  logic irq_q = 1'b0;
  int mismatches = 0;
  int num_checks = 0;
  int resets = 0;
  int irq_rises = 0;
  int r0;
  int n0;

  wdp_top u_wdp_top (.mclk(mclk), .rst_n(rst_n), .por_n(por_n),
    .slow_timebase_clock(slow_timebase_clock), .halt_mode(halt_mode),
    .programming_voltage_pin(programming_voltage_pin), .bus_req(bus_req),
    .rd_data(rd_data), .sys_reset_req(sys_reset_req),
    .periodic_irq(periodic_irq), .periodic_irq_ack(periodic_irq_ack));

  always #2.5 mclk = ~mclk;

  // Counts cycles with a reset request and interrupt edges, acknowledges each request
  always @(posedge mclk) begin
    if (sys_reset_req)
      resets <= resets + 1;
    if (periodic_irq && !irq_q)
      irq_rises <= irq_rises + 1;
    irq_q <= periodic_irq;
    periodic_irq_ack <= periodic_irq && !periodic_irq_ack;
  end

  // ************************************************************
  // Bus, timebase and compare tasks
  // ************************************************************
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req <= '0;
  endtask

  task bus_rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req <= '0;
    #1 chk(rd_data, exp);
  endtask

  task ticks(input int n);
    repeat (n) begin
      @(posedge mclk) slow_timebase_clock <= 1'b1;
      @(posedge mclk);
      @(posedge mclk) slow_timebase_clock <= 1'b0;
      @(posedge mclk);
    end
  endtask

  task do_rst(input logic pin);
    @(posedge mclk);
    rst_n <= 1'b0;
    programming_voltage_pin <= pin;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    r0 = resets;
  endtask

  task reset_seen(input logic exp);
    @(posedge mclk);
    #1 chk(8'(resets != r0), 8'(exp));
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task t_reset_vals;
    do_rst(1'b0);
    bus_rd(16'h7029, 8'h28);
    bus_rd(16'h7025, 8'h28);
    bus_rd(16'h7027, 8'h00);
    bus_rd(16'h7021, 8'h00);
    bus_rd(16'h7020, 8'h00);
    ticks(5);
    bus_wr(16'h7023, 8'h77);
    bus_rd(16'h7023, 8'h05);
  endtask

  task automatic t_keys;
    logic [7:0] keys [9] = '{8'hAA, 8'hAA, 8'h55, 8'h55, 8'h55, 8'hAA,
      8'hAA, 8'h55, 8'hAA};
    logic armed;
    logic [7:0] cnt;
    do_rst(1'b0);
    armed = 1'b0;
    cnt = 8'h00;
    foreach (keys[i]) begin
      ticks(1);
      cnt = cnt + 8'h01;
      bus_wr(16'h7025, keys[i]);
      if (keys[i] == 8'h55)
        armed = 1'b1;
      else if (armed) begin
        cnt = 8'h00;
        armed = 1'b0;
      end
      bus_rd(16'h7023, cnt);
    end
    reset_seen(1'b0);
  endtask

  task automatic t_bad_key;
    logic [7:0] bad [4] = '{8'h23, 8'h00, 8'hFF, 8'h54};
    foreach (bad[i]) begin
      do_rst(1'b0);
      ticks(2);
      bus_wr(16'h7025, bad[i]);
      reset_seen(1'b1);
      do_rst(1'b0);
      bus_rd(16'h7029, 8'hA8);
      bus_rd(16'h7023, 8'h00);
      if (i == 0) begin
        bus_wr(16'h7029, 8'hA8);
        bus_rd(16'h7029, 8'h28);
      end
    end
  endtask

  task t_overflow;
    do_rst(1'b0);
    bus_wr(16'h7029, 8'hA8);
    ticks(256);
    bus_rd(16'h7023, 8'h00);
    reset_seen(1'b0);
    ticks(1);
    reset_seen(1'b1);
    do_rst(1'b0);
    bus_rd(16'h7029, 8'hA8);
    ticks(256);
    bus_wr(16'h7025, 8'h55);
    bus_wr(16'h7025, 8'hAA);
    ticks(2);
    reset_seen(1'b0);
  endtask

  task t_taps;
    for (int k = 1; k < 8; k++) begin
      do_rst(1'b0);
      bus_wr(16'h7029, 8'h28 | 8'(k));
      ticks(64);
      bus_rd(16'h7023, 8'(64 >> (k < 2 ? 0 : k - 1)));
    end
  endtask

  task t_check_bits;
    for (int p = 0; p < 8; p++) begin
      do_rst(1'b0);
      bus_wr(16'h7029, 8'(p << 3) | 8'h02);
      repeat (4) @(posedge mclk);
      #1 chk(8'(sys_reset_req), 8'(p != 5));
    end
  endtask

  task t_defeat;
    for (int c = 0; c < 3; c++) begin
      do_rst(c != 0);
      bus_wr(16'h7029, c == 1 ? 8'h28 : 8'h68);
      ticks(4);
      bus_rd(16'h7023, c == 2 ? 8'h00 : 8'h04);
    end
  endtask

  task automatic t_periodic;
    int div [6] = '{4, 16, 64, 128, 256, 512};
    do_rst(1'b0);
    bus_wr(16'h7029, 8'h2F);
    ticks(200);
    bus_wr(16'h7021, 8'h5A);
    bus_rd(16'h7021, 8'h00);
    ticks(56);
    bus_rd(16'h7021, 8'h01);
    for (int s = 0; s < 6; s++) begin
      do_rst(1'b0);
      bus_wr(16'h7029, 8'h2F);
      bus_wr(16'h7027, 8'h40 | 8'(s));
      n0 = irq_rises;
      ticks(512);
      repeat (4) @(posedge mclk);
      #1 chk(8'(irq_rises - n0), 8'(512 / div[s]));
      bus_rd(16'h7027, 8'hC0 | 8'(s));
    end
    bus_wr(16'h7027, 8'h45);
    bus_rd(16'h7027, 8'h45);
    n0 = irq_rises;
    bus_wr(16'h7027, 8'hC5);
    bus_wr(16'h7027, 8'h00);
    ticks(8);
    bus_rd(16'h7027, 8'h80);
    #1 chk(8'(irq_rises - n0), 8'h00);
    @(posedge mclk) halt_mode <= 1'b1;
    bus_wr(16'h7021, 8'h00);
    bus_wr(16'h7027, 8'h40);
    n0 = irq_rises;
    ticks(256);
    bus_rd(16'h7021, 8'h00);
    chk(8'(irq_rises - n0), 8'h00);
    @(posedge mclk) halt_mode <= 1'b0;
    ticks(4);
    repeat (2) @(posedge mclk);
    #1 chk(8'(irq_rises - n0), 8'h01);
  endtask

  // ************************************************************
  // Sequence and verdict
  // ************************************************************
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge mclk);
    por_n <= 1'b1;
    rst_n <= 1'b1;
    t_reset_vals;
    t_keys;
    t_bad_key;
    t_overflow;
    t_taps;
    t_check_bits;
    t_defeat;
    t_periodic;
    conclude;
  end

  initial begin
    #300000;
    mismatches++;
    conclude;
  end
endmodule
